// ---- src/rtm_ctrl.sv ----
// reverse turbo mode control, charge decode and ripple modulator with axi4-lite registers
// How it works
// [RULE1] halt charging first, then reverse into turbo
// [RULE2] enter turbo: near limit, low charge, low error
// [RULE3] secondary limit when two-level limit enabled
// [RULE4] leave turbo when charge exceeds 150mA
// [RULE5] leave turbo: below limit and error low
// [RULE6] leave turbo after 40ms low discharge
// [RULE7] turbo bit 0 permits boost, 1 forbids
// [RULE8] charge only when enabled and current nonzero
// [RULE9] host sets both settings zero or nonzero
// [RULE10] minimum low-side on-time stretches the period
// [RULE11] zero-cross mode drops low gate at zero
// [RULE12] pulse ends at upper level, restarts at error
// [RULE13] control word bit 0 drives turbo bit
// [RULE14] host disables charging before enabling turbo
// [RULE15] qualification timer restarts on high discharge
`timescale 1ns/1ps
module rtm_ctrl #(
   parameter int unsigned QUAL_CYCLES = rtm_pkg::QUAL_CYCLES
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // register bus
   input wire rtm_pkg::rtm_axi_req_t axi_req,
   output rtm_pkg::rtm_axi_rsp_t axi_rsp,
   // comparator flags from the analog side
   input wire rtm_pkg::rtm_cmp_t cmp_async,
   // power stage and status
   output rtm_pkg::rtm_gate_t gate,
   output logic turbo_active,
   output logic charge_run,
   output logic boost_allow,
   output logic charge_halted
);
   localparam int QW = rtm_pkg::QTW;
   localparam logic [QW-1:0] QUAL_LAST = QW'(QUAL_CYCLES - 1);
   localparam logic [rtm_pkg::LSMIN_W-1:0] LSMIN_ONE = 8'h01;

   rtm_pkg::rtm_state_t q;
   rtm_pkg::rtm_state_t d;
   rtm_pkg::rtm_cmp_t s;
   logic near;
   logic perm;
   logic chg_ok;
   logic run;
   logic min_met;
   logic qual_done;
   logic [rtm_pkg::DATA_W-1:0] wr_val;

   rtm_sync #(.W($bits(rtm_pkg::rtm_cmp_t))) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .d(cmp_async),
      .q(s)
   );

   function automatic logic [rtm_pkg::DATA_W-1:0] merge(input logic [rtm_pkg::DATA_W-1:0] old,
         input logic [rtm_pkg::DATA_W-1:0] nw, input logic [rtm_pkg::STRB_W-1:0] strb);
      logic [rtm_pkg::DATA_W-1:0] r;
      r = old;
      for (int i = 0; i < rtm_pkg::STRB_W; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [rtm_pkg::DATA_W-1:0] cur_val(input rtm_pkg::rtm_state_t st,
         input logic [rtm_pkg::ADDR_W-1:0] a);
      logic [rtm_pkg::DATA_W-1:0] v;
      v = '0;
      unique case (a)
         rtm_pkg::OFS_CTRL: v = rtm_pkg::DATA_W'(st.ctrl);
         rtm_pkg::OFS_CHG: v = rtm_pkg::DATA_W'(st.chg);
         rtm_pkg::OFS_VMIN: v = rtm_pkg::DATA_W'(st.vmin);
         rtm_pkg::OFS_LSMIN: v = rtm_pkg::DATA_W'(st.lsmin);
         rtm_pkg::OFS_STAT: v = rtm_pkg::DATA_W'({st.mode, st.zero_seen, st.gate, st.halt, st.boost,
                                                  st.charge, st.turbo});
         default: v = '0;
      endcase
      return v;
   endfunction

   function automatic logic mapped(input logic [rtm_pkg::ADDR_W-1:0] a);
      return a == rtm_pkg::OFS_CTRL || a == rtm_pkg::OFS_CHG || a == rtm_pkg::OFS_VMIN ||
             a == rtm_pkg::OFS_LSMIN || a == rtm_pkg::OFS_STAT;
   endfunction

   always_comb begin
      d = q;
      wr_val = '0;
      // write path: address and data taken independently
      if (axi_req.awvalid && q.rsp.awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = axi_req.awaddr;
      end
      if (axi_req.wvalid && q.rsp.wready) begin
         d.w_have = 1'b1;
         d.w_data = axi_req.wdata;
         d.w_strb = axi_req.wstrb;
      end
      if (q.rsp.bvalid && axi_req.bready) begin
         d.rsp.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
         wr_val = merge(cur_val(q, q.aw_addr), q.w_data, q.w_strb);
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.rsp.bvalid = 1'b1;
         d.rsp.bresp = rtm_pkg::RESP_OKAY;
         unique case (q.aw_addr)
            rtm_pkg::OFS_CTRL: d.ctrl = wr_val[rtm_pkg::CTL_W-1:0]; // [RULE13]
            rtm_pkg::OFS_CHG: d.chg = wr_val[rtm_pkg::CHG_W-1:0];
            rtm_pkg::OFS_VMIN: d.vmin = wr_val[rtm_pkg::VMIN_W-1:0];
            rtm_pkg::OFS_LSMIN: d.lsmin = wr_val[rtm_pkg::LSMIN_W-1:0];
            // status is read-only; writes to it are accepted and dropped
            rtm_pkg::OFS_STAT: d.rsp.bresp = rtm_pkg::RESP_OKAY;
            default: d.rsp.bresp = rtm_pkg::RESP_SLVERR;
         endcase
      end
      d.rsp.awready = !d.aw_have;
      d.rsp.wready = !d.w_have;
      // read path
      if (q.rsp.rvalid && axi_req.rready) begin
         d.rsp.rvalid = 1'b0;
      end
      if (axi_req.arvalid && q.rsp.arready) begin
         d.rsp.rvalid = 1'b1;
         d.rsp.rdata = cur_val(q, axi_req.araddr);
         d.rsp.rresp = mapped(axi_req.araddr) ? rtm_pkg::RESP_OKAY : rtm_pkg::RESP_SLVERR;
      end
      d.rsp.arready = !d.rsp.rvalid;

      // mode decisions on synchronised flags
      near = q.ctrl[rtm_pkg::CTL_TWO_LVL] ? s.near_sec : s.near_pri; // [RULE3]
      perm = !q.ctrl[rtm_pkg::CTL_TURBO_DIS]; // [RULE7]
      // next-state settings, so a write that clears charging stops it in the same cycle
      chg_ok = d.ctrl[rtm_pkg::CTL_CHG_EN] && (d.chg != '0); // [RULE8]
      // a zero charge setting with charging enabled simply keeps charging off
      qual_done = q.turbo && s.dis_low && q.qual_cnt == QUAL_LAST; // [RULE6]
      d.boost = perm;
      // stop charging first; reversal needs the halt already in place
      if (!(q.ctrl[rtm_pkg::CTL_HYBRID] && perm)) begin
         d.halt = 1'b0;
      end else if (near) begin
         d.halt = 1'b1; // [RULE1]
      end else if (!q.turbo && s.adp_below) begin
         d.halt = 1'b0;
      end
      if (q.turbo) begin
         if (!(q.ctrl[rtm_pkg::CTL_HYBRID] && perm) || s.chg_over || // [RULE4]
             (s.adp_below && s.comp_low) || qual_done) begin // [RULE5]
            d.turbo = 1'b0;
         end
      end else if (q.ctrl[rtm_pkg::CTL_HYBRID] && perm && q.halt && near && !s.chg_over && s.comp_low) begin
         d.turbo = 1'b1; // [RULE1] [RULE2]
      end
      if (q.turbo && s.dis_low && !qual_done) begin
         d.qual_cnt = q.qual_cnt + QW'(1);
      end else begin
         d.qual_cnt = '0; // [RULE15]
      end
      d.charge = chg_ok && !d.halt && !d.turbo; // [RULE8]

      // ripple modulator
      run = q.charge || q.turbo;
      min_met = q.ls_cnt >= q.lsmin;
      unique case (q.mode)
         rtm_pkg::MOD_IDLE: begin
            if (run && s.rip_comp) begin
               d.mode = rtm_pkg::MOD_HIGH; // [RULE12]
            end
         end
         rtm_pkg::MOD_HIGH: begin
            if (!run) begin
               d.mode = rtm_pkg::MOD_IDLE;
            end else if (s.rip_upper) begin
               d.mode = rtm_pkg::MOD_LOW; // [RULE12]
            end
         end
         rtm_pkg::MOD_LOW: begin
            // every exit waits for the minimum on-time, which stretches the period
            if (min_met) begin // [RULE10]
               if (q.ctrl[rtm_pkg::CTL_ZCE] && (q.zero_seen || s.phase_zero)) begin
                  d.mode = rtm_pkg::MOD_IDLE; // [RULE11]
               end else if (!run) begin
                  d.mode = rtm_pkg::MOD_IDLE;
               end else if (s.rip_comp) begin
                  d.mode = rtm_pkg::MOD_HIGH; // [RULE12]
               end
            end
         end
         default: d.mode = rtm_pkg::MOD_IDLE;
      endcase
      if (q.mode == rtm_pkg::MOD_LOW) begin
         d.zero_seen = q.zero_seen || s.phase_zero;
         d.ls_cnt = (q.ls_cnt == '1) ? q.ls_cnt : q.ls_cnt + LSMIN_ONE;
      end else begin
         d.zero_seen = 1'b0;
         d.ls_cnt = '0;
      end
      d.gate.high = d.mode == rtm_pkg::MOD_HIGH;
      d.gate.low = d.mode == rtm_pkg::MOD_LOW;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= rtm_pkg::ST_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   assign axi_rsp = q.rsp;
   assign gate = q.gate;
   assign turbo_active = q.turbo;
   assign charge_run = q.charge;
   assign boost_allow = q.boost;
   assign charge_halted = q.halt;

   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   halt_before_turbo_a: assert property ($rose(q.turbo) |-> $past(q.halt)) // [RULE1]
      else $error("turbo entered without halted charging");
   entry_conds_a: assert property ($rose(q.turbo) |-> $past(!s.chg_over && s.comp_low)) // [RULE2]
      else $error("turbo entered without entry conditions");
   limit_select_a: assert property ($rose(q.turbo) |-> // [RULE3]
      $past(q.ctrl[rtm_pkg::CTL_TWO_LVL] ? s.near_sec : s.near_pri))
      else $error("turbo entered against wrong adapter limit");
   charge_exit_a: assert property (ce && q.turbo && s.chg_over |=> !q.turbo) // [RULE4]
      else $error("turbo kept with charge current high");
   loop_exit_a: assert property (ce && q.turbo && s.adp_below && s.comp_low |=> !q.turbo) // [RULE5]
      else $error("turbo kept below limit with low error");
   qual_exit_a: assert property (ce && q.turbo && s.dis_low && q.qual_cnt == QUAL_LAST |=> !q.turbo) // [RULE6]
      else $error("turbo kept after qualification time");
   qual_restart_a: assert property (ce && !(q.turbo && s.dis_low) |=> q.qual_cnt == '0) // [RULE15]
      else $error("qualification timer not restarted");
   boost_gate_a: assert property (ce && q.ctrl[rtm_pkg::CTL_TURBO_DIS] |=> !q.turbo && !q.boost) // [RULE7]
      else $error("boost allowed while turbo bit set");
   charge_gate_a: assert property (q.charge |-> q.ctrl[rtm_pkg::CTL_CHG_EN] && q.chg != '0) // [RULE8]
      else $error("charging without enable or current");
   min_on_a: assert property ($fell(q.gate.low) |-> $past(q.ls_cnt) >= $past(q.lsmin)) // [RULE10]
      else $error("low gate shorter than minimum");
   zero_cross_a: assert property (ce && q.mode == rtm_pkg::MOD_LOW && q.ctrl[rtm_pkg::CTL_ZCE] && // [RULE11]
      q.zero_seen && q.ls_cnt >= q.lsmin |=> !q.gate.low && !q.gate.high)
      else $error("low gate kept after zero crossing");
   pulse_end_a: assert property (ce && q.gate.high && s.rip_upper |=> !q.gate.high) // [RULE12]
      else $error("pulse not ended at upper level");

   turbo_entry_c: cover property ($rose(q.turbo));
   turbo_timeout_c: cover property (q.turbo && q.qual_cnt == QUAL_LAST ##1 !q.turbo);
   zero_idle_c: cover property (q.mode == rtm_pkg::MOD_LOW && q.ctrl[rtm_pkg::CTL_ZCE] ##1
      q.mode == rtm_pkg::MOD_IDLE);
   stretch_c: cover property (q.mode == rtm_pkg::MOD_LOW && s.rip_comp && q.ls_cnt < q.lsmin);
endmodule

// ---- src/rtm_pkg.sv ----
// constants and carrier types for the reverse turbo mode controller
package rtm_pkg;
   // bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CHG = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_VMIN = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_LSMIN = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h10;
   // first_control_word fields
   localparam int CTL_TURBO_DIS = 0;
   localparam int CTL_TWO_LVL = 1;
   localparam int CTL_CHG_EN = 2;
   localparam int CTL_HYBRID = 3;
   localparam int CTL_ZCE = 4;
   localparam int CTL_W = 5;
   localparam logic [CTL_W-1:0] CTRL_RST = 5'h01;
   // setting widths and reset values
   localparam int CHG_W = 13;
   localparam int VMIN_W = 13;
   localparam int LSMIN_W = 8;
   localparam logic [CHG_W-1:0] CHG_RST = 13'h0000;
   localparam logic [VMIN_W-1:0] VMIN_RST = 13'h0000;
   localparam logic [LSMIN_W-1:0] LSMIN_RST = 8'h14;
   // 40 ms low-discharge qualification
   localparam int unsigned QUAL_TIME_MS = 40;
   localparam int unsigned CLK_KHZ = 200000;
   localparam int unsigned QUAL_CYCLES = QUAL_TIME_MS * CLK_KHZ;
   localparam int QTW = 24;

   typedef enum logic [2:0] {
      MOD_IDLE = 3'h1,
      MOD_HIGH = 3'h2,
      MOD_LOW = 3'h4
   } rtm_mod_t;

   typedef struct packed {
      logic near_pri;
      logic near_sec;
      logic adp_below;
      logic chg_over;
      logic dis_low;
      logic comp_low;
      logic rip_upper;
      logic rip_comp;
      logic phase_zero;
   } rtm_cmp_t;

   typedef struct packed {
      logic high;
      logic low;
   } rtm_gate_t;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } rtm_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } rtm_axi_rsp_t;

   typedef struct packed {
      rtm_axi_rsp_t rsp;
      logic aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [DATA_W-1:0] w_data;
      logic [STRB_W-1:0] w_strb;
      logic [CTL_W-1:0] ctrl;
      logic [CHG_W-1:0] chg;
      logic [VMIN_W-1:0] vmin;
      logic [LSMIN_W-1:0] lsmin;
      logic turbo;
      logic halt;
      logic charge;
      logic boost;
      logic [QTW-1:0] qual_cnt;
      rtm_mod_t mode;
      rtm_gate_t gate;
      logic [LSMIN_W-1:0] ls_cnt;
      logic zero_seen;
   } rtm_state_t;

   localparam rtm_state_t ST_RST = '{mode: MOD_IDLE, ctrl: CTRL_RST, chg: CHG_RST, vmin: VMIN_RST,
                                     lsmin: LSMIN_RST, default: '0};
endpackage

// ---- src/rtm_sync.sv ----
// two-stage synchroniser for asynchronous comparator flags
`timescale 1ns/1ps
module rtm_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // flags
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [1:0][W-1:0] stages_q;
   logic [1:0][W-1:0] stages_d;

   // first stage feeds only the second
   always_comb begin
      stages_d = {stages_q[0], d};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stages_q <= '0;
      end else if (ce) begin
         stages_q <= stages_d;
      end
   end

   assign q = stages_q[1];
endmodule

// ---- testbench/rtm_pwr_model.sv ----
// power stage and ripple comparator model for the controller's far side
`timescale 1ns/1ps
module rtm_pwr_model #(
   parameter int HI_LEN = 3,
   parameter int CMP_LEN = 2,
   parameter int Z_LEN = 1
) (
   // clock
   input wire logic aclk,
   // gate drive from the controller
   input wire rtm_pkg::rtm_gate_t gate,
   // emulated comparator levels
   output logic rip_upper,
   output logic rip_comp,
   output logic phase_zero
);
   int hi_n = 0;
   int off_n = 0;
   int lo_n = 0;
   // ripple rises while high side conducts, decays otherwise
   always @(posedge aclk) begin
      hi_n <= gate.high ? hi_n + 1 : 0;
      off_n <= gate.high ? 0 : off_n + 1;
      lo_n <= gate.low ? lo_n + 1 : 0;
   end
   assign rip_upper = hi_n >= HI_LEN;
   // short decay: intended low time below the minimum, so stretching shows
   assign rip_comp = off_n >= CMP_LEN;
   assign phase_zero = lo_n >= Z_LEN;
endmodule

// ---- testbench/rtm_ctrl_tb.sv ----
// self-checking bench for the reverse turbo mode controller
`timescale 1ns/1ps
module rtm_ctrl_tb;
   logic aclk = 0;
   logic aresetn = 0;
   rtm_pkg::rtm_axi_req_t req = '0;
   rtm_pkg::rtm_axi_rsp_t rsp;
   rtm_pkg::rtm_cmp_t cmp;
   rtm_pkg::rtm_gate_t gate;
   logic [5:0] fl = '0;
   logic ru, rc, pz, turbo, chg_run, boost, halted;
   logic pl = 0;
   logic pt = 0;
   logic fell = 0;
   logic [31:0] d;
   logic [1:0] r;
   int error_cnt = 0;
   int n_tests = 0;
   int run = 0;
   int min_low = 99;
   int direct = 0;
   // rows: turbo off bit, charge enable, nonzero setting | charge, boost
   logic [4:0] rows [8] = '{5'h01, 5'h05, 5'h09, 5'h0f, 5'h10, 5'h14, 5'h18, 5'h1e};
   always #2.5 aclk = ~aclk;
   assign cmp = {fl, ru, rc, pz};
   rtm_ctrl #(.QUAL_CYCLES(50)) u_rtm_ctrl (.aclk(aclk), .aresetn(aresetn), .ce(1'h1), .axi_req(req),
      .axi_rsp(rsp), .cmp_async(cmp), .gate(gate), .turbo_active(turbo), .charge_run(chg_run),
      .boost_allow(boost), .charge_halted(halted));
   rtm_pwr_model u_rtm_pwr_model (.aclk(aclk), .gate(gate), .rip_upper(ru), .rip_comp(rc), .phase_zero(pz));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_sim;
      if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
      req.awvalid <= 1'h1;
      req.wvalid <= 1'h1;
      req.awaddr <= a;
      req.wdata <= v;
      req.wstrb <= 4'hf;
      req.bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'h0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'h0;
      end while (!(rsp.bvalid && req.bready));
      // bready stays up between writes; only the watchdog ends a stuck wait
      s = rsp.bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
      req.arvalid <= 1'h1;
      req.araddr <= a;
      req.rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'h0;
      end while (!(rsp.rvalid && req.rready));
      v = rsp.rdata;
      s = rsp.rresp;
   endtask
   task automatic go(input logic [5:0] f, input int n);
      fl <= f;
      repeat (n) @(posedge aclk);
   endtask
   // low-gate run lengths, direct low-to-high handovers, turbo exits
   always @(posedge aclk) begin
      pl <= gate.low;
      pt <= turbo;
      if (gate.low) run <= run + 1;
      else run <= 0;
      if (pl && !gate.low && run < min_low) min_low <= run;
      if (pl && !gate.low && gate.high) direct <= direct + 1;
      if (pt && !turbo) fell <= 1'h1;
      if (gate.low && gate.high) chk("gate overlap", 32'h1, 32'h0);
   end
   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      repeat (3) @(posedge aclk);
      chk("run after reset", chg_run, 32'h0);
      chk("boost after reset", boost, 32'h0);
      rd(rtm_pkg::OFS_CTRL, d, r);
      chk("ctrl reset", d, 32'h1);
      rd(rtm_pkg::OFS_CHG, d, r);
      chk("chg reset", d, 32'h0);
      rd(rtm_pkg::OFS_LSMIN, d, r);
      chk("lsmin reset", d, 32'h14);
      rd(8'h20, d, r);
      chk("unmapped read", r, rtm_pkg::RESP_SLVERR);
      wr(8'h20, 32'h1f, r);
      chk("unmapped write", r, rtm_pkg::RESP_SLVERR);
      wr(rtm_pkg::OFS_STAT, 32'hff, r);
      chk("status write", r, rtm_pkg::RESP_OKAY);
      // settings kept both non-zero by the host
      wr(rtm_pkg::OFS_VMIN, 32'h100, r);
      rd(rtm_pkg::OFS_VMIN, d, r);
      chk("vmin readback", d, 32'h100);
      wr(rtm_pkg::OFS_LSMIN, 32'h4, r);
      for (int i = 0; i < 8; i++) begin
         wr(rtm_pkg::OFS_CTRL, {29'h0, rows[i][3], 1'h0, rows[i][4]}, r);
         wr(rtm_pkg::OFS_CHG, rows[i][2] ? 32'h100 : 32'h0, r);
         repeat (4) @(posedge aclk);
         chk("charge run", chg_run, rows[i][1]);
         chk("boost allow", boost, rows[i][0]);
         rd(rtm_pkg::OFS_STAT, d, r);
         chk("status decode", d[2:1], {rows[i][0], rows[i][1]});
      end
      wr(rtm_pkg::OFS_CTRL, 32'h14, r);
      repeat (5) @(posedge aclk);
      #1 direct = 0;
      repeat (80) @(posedge aclk);
      chk("zero cross idle", direct, 32'h0);
      wr(rtm_pkg::OFS_CTRL, 32'h04, r);
      repeat (5) @(posedge aclk);
      #1 direct = 0;
      repeat (80) @(posedge aclk);
      chk("ccm handover", direct > 0, 32'h1);
      chk("low stretch", min_low >= 5, 32'h1);
      // bypass with turbo allowed; charging is enabled with a nonzero setting, so it runs until halted
      wr(rtm_pkg::OFS_CTRL, 32'h0c, r);
      go(6'h00, 6);
      chk("bypass charging", chg_run, 32'h1);
      go(6'h20, 6);
      chk("halt first", halted, 32'h1);
      chk("charge stopped", chg_run, 32'h0);
      chk("near alone", turbo, 32'h0);
      go(6'h25, 6);
      chk("charge too high", turbo, 32'h0);
      go(6'h21, 8);
      chk("turbo entry", turbo, 32'h1);
      go(6'h25, 6);
      chk("charge exit", turbo, 32'h0);
      go(6'h21, 8);
      chk("turbo reentry", turbo, 32'h1);
      go(6'h09, 6);
      chk("below limit exit", turbo, 32'h0);
      wr(rtm_pkg::OFS_CTRL, 32'h0e, r);
      go(6'h21, 8);
      chk("primary ignored", turbo, 32'h0);
      go(6'h11, 8);
      chk("secondary entry", turbo, 32'h1);
      fell = 1'h0;
      go(6'h13, 30);
      go(6'h11, 2);
      go(6'h13, 45);
      chk("qual restart", fell, 32'h0);
      go(6'h13, 15);
      chk("low discharge exit", fell, 32'h1);
      wr(rtm_pkg::OFS_CTRL, 32'h0f, r);
      repeat (5) @(posedge aclk);
      chk("turbo forbidden", turbo, 32'h0);
      chk("boost forbidden", boost, 32'h0);
      end_sim;
   end
   // cut a hang short well past the expected run length
   initial begin
      repeat (6000) @(posedge aclk);
      error_cnt++;
      end_sim;
   end
endmodule
